// *** hw/tpc_top.sv ***
// Timer control register, option byte, prescaler and timer data counter
//
// Notes on behaviour
// RQ1: Counter reaching zero sets request flag.
// RQ2: Reset or software zero write clears flag.
// RQ3: Interrupt out is flag unless masked.
// RQ4: Mask bit blocks; reset sets, software clears.
// RQ5: Source bit picks count pin or internal.
// RQ6: Source and gate bits pick clock mode.
// RQ7: Legacy layout holds gate enable at one.
// RQ8: Prescaler clear pulses; reads zero when programmable.
// RQ9: Legacy: clear reads one, writes ignored.
// RQ10: Select n divides by two to n.
// RQ11: Software clears prescaler when changing select.
// RQ12: Legacy exposes only flag and mask.
// RQ13: Legacy takes source and divide from option.
// RQ14: Programmable layout loads fields from option.
// RQ15: Option bit five selects count source.
// RQ16: Option low bits encode prescaler division.
// RQ17: Blank option byte means programmable, zeros.
// RQ18: Option bit six selects register layout.
// RQ19: Prescaler tap pulse decrements counter.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module tpc_top (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [tpc_pkg::TPC_DW-1:0] hwdata,
  input  wire logic                      hready,
  output      logic                      hreadyout,
  output      logic [tpc_pkg::TPC_DW-1:0] hrdata,
  output      logic                      hresp,
  // Count pin and option straps
  input  wire logic                      count_pin,
  input  wire logic [7:0]                option_pins,
  // Interrupt to processor
  output      logic                      timer_irq
);
  import tpc_pkg::*;

  tpc_regs_t  r;
  tpc_regs_t  n;

  logic       acc;
  logic [1:0] sel_a;
  logic       legacy;
  logic       src_e;
  logic       gate_e;
  logic [2:0] sel_e;
  logic       tick;
  logic       ev;
  logic [6:0] lowm;
  logic       tap;
  logic       wr_tcr;
  logic       wr_tdr;
  logic       psc_clr;
  logic       set_irq;
  logic [7:0] rd_tcr;
  logic [7:0] rd_mux;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;

    // Address phase decode
    acc   = hsel && htrans[1] && hready;
    sel_a = TPC_SEL_NONE;
    if (haddr[31:14] == 18'h00000 && haddr[1:0] == 2'h0) begin
      case (haddr[13:2])
        TPC_TDR_IDX: sel_a = TPC_SEL_TDR;
        TPC_TCR_IDX: sel_a = TPC_SEL_TCR;
        TPC_OPT_IDX: sel_a = TPC_SEL_OPT;
        default:     sel_a = TPC_SEL_NONE;
      endcase
    end
    n.wr_pend = acc && hwrite;
    n.wr_reg  = sel_a;

    // Data phase writes
    wr_tcr = r.wr_pend && r.wr_reg == TPC_SEL_TCR;
    wr_tdr = r.wr_pend && r.wr_reg == TPC_SEL_TDR;

    // Effective clock controls
    legacy = r.opt[TPC_B_LEGACY];                         // RQ18
    src_e  = legacy ? r.opt[TPC_B_SRC] : r.src;           // RQ13 RQ15
    gate_e = legacy ? 1'b1 : r.gate;                      // RQ7
    sel_e  = legacy ? r.opt[2:0] : r.sel;                 // RQ13 RQ16

    // Internal clock is a one-in-four tick
    tick  = r.ph2 == TPC_PH2_LAST;
    n.ph2 = r.ph2 + 2'h1;
    n.pin_d = count_pin;

    case ({src_e, gate_e})                                // RQ5 RQ6
      2'b00:   ev = tick;
      2'b01:   ev = tick && count_pin;
      2'b10:   ev = 1'b0;
      2'b11:   ev = count_pin && !r.pin_d;
      default: ev = 1'b0;
    endcase

    // Prescaler: tap when the low sel bits roll over
    psc_clr = wr_tcr && hwdata[TPC_B_PSC] && !legacy;     // RQ8 RQ9 RQ11
    lowm    = ~(7'h7F << sel_e);                          // RQ10
    tap     = ev && !psc_clr && (&(r.pre | ~lowm));       // RQ10
    if (psc_clr) begin
      n.pre = TPC_PRE_RESET;                              // RQ8
    end else if (ev) begin
      n.pre = r.pre + 7'h01;
    end

    // Timer data counter
    set_irq = tap && !wr_tdr && r.tdr == 8'h01;           // RQ1
    if (wr_tdr) begin
      n.tdr = hwdata[7:0];
    end else if (tap) begin
      n.tdr = r.tdr - 8'h01;                              // RQ19
    end

    // Control register writes
    if (wr_tcr) begin
      if (!hwdata[TPC_B_IRQ]) begin
        n.irq = 1'b0;                                     // RQ2
      end
      n.mask = hwdata[TPC_B_MASK];                        // RQ4
      if (!legacy) begin
        n.src  = hwdata[TPC_B_SRC];
        n.gate = hwdata[TPC_B_GATE];
        n.sel  = hwdata[2:0];
      end
    end
    if (set_irq) begin
      n.irq = 1'b1;                                       // RQ1
    end

    // Option capture after reset release
    case (r.st)
      TPC_LOAD: begin
        n.opt = option_pins;                              // RQ17
        if (!option_pins[TPC_B_LEGACY]) begin
          n.src  = option_pins[TPC_B_SRC];                // RQ14
          n.gate = option_pins[TPC_B_GATE];               // RQ14
          n.sel  = option_pins[2:0];                      // RQ14
        end
        n.st = TPC_RUN;
      end
      TPC_RUN: n.st = TPC_RUN;
      default: n.st = TPC_LOAD;
    endcase

    // Read data from post-write values
    if (legacy) begin
      rd_tcr = {n.irq, n.mask, TPC_HIDDEN};               // RQ9 RQ12
    end else begin
      rd_tcr = {n.irq, n.mask, n.src, n.gate, 1'b0, n.sel}; // RQ8
    end
    case (sel_a)
      TPC_SEL_TDR: rd_mux = n.tdr;
      TPC_SEL_TCR: rd_mux = rd_tcr;
      TPC_SEL_OPT: rd_mux = n.opt;
      default:     rd_mux = 8'h00;
    endcase
    if (acc && !hwrite) begin
      n.rdata = {24'h000000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r.st      <= TPC_LOAD;
      r.opt     <= TPC_OPT_RESET;
      r.irq     <= 1'b0;                                  // RQ2
      r.mask    <= 1'b1;                                  // RQ4
      r.src     <= 1'b0;
      r.gate    <= 1'b0;
      r.sel     <= TPC_SEL_RESET;
      r.pre     <= TPC_PRE_RESET;
      r.tdr     <= TPC_TDR_RESET;
      r.ph2     <= 2'h0;
      r.pin_d   <= 1'b0;
      r.wr_pend <= 1'b0;
      r.wr_reg  <= TPC_SEL_NONE;
      r.rdata   <= 32'h00000000;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r.rdata;
  assign timer_irq = r.irq && !r.mask;                    // RQ3

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_tap_to_zero;
    tap && !wr_tdr && r.tdr == 8'h01;
  endsequence

  sequence s_tcr_read;
    acc && !hwrite && sel_a == TPC_SEL_TCR && r.st == TPC_RUN;
  endsequence

  sequence s_load_prog;
    r.st == TPC_LOAD && !option_pins[TPC_B_LEGACY];
  endsequence

  sequence s_legacy_write;
    wr_tcr && legacy;
  endsequence

  sequence s_tdr_load;
    wr_tdr;
  endsequence

  sequence s_opt_read;
    acc && !hwrite && sel_a == TPC_SEL_OPT;
  endsequence

  a_irq_set_zero: assert property ( // RQ1
    s_tap_to_zero |=> r.irq && r.tdr == 8'h00)
    else $error("request flag not set at zero");

  a_irq_sw_clear: assert property ( // RQ2
    wr_tcr && !hwdata[TPC_B_IRQ] && !set_irq |=> !r.irq)
    else $error("request flag not cleared by write");

  a_irq_out_gate: assert property ( // RQ3
    $rose(r.irq) && !r.mask |-> timer_irq)
    else $error("unmasked request not signalled");

  a_mask_sw_only: assert property ( // RQ4
    $fell(r.mask) |-> $past(wr_tcr) && !$past(hwdata[TPC_B_MASK]))
    else $error("mask cleared without write");

  a_ext_pin_edge: assert property ( // RQ6
    src_e && gate_e && count_pin && !r.pin_d |-> ev)
    else $error("external edge not counted");

  a_psc_read_zero: assert property ( // RQ8
    s_tcr_read and !legacy |=> r.rdata[TPC_B_PSC] == 1'b0)
    else $error("prescaler clear not read as zero");

  a_psc_clear_pre: assert property ( // RQ8
    psc_clr |=> r.pre == 7'h00 && $stable(r.tdr) || $past(wr_tdr))
    else $error("prescaler not cleared");

  a_legacy_hidden: assert property ( // RQ12
    s_tcr_read and legacy |=> r.rdata[5:0] == 6'h3F)
    else $error("legacy bits not read as ones");

  a_option_load: assert property ( // RQ14
    s_load_prog |=> r.sel == $past(option_pins[2:0])
      && r.src == $past(option_pins[TPC_B_SRC]))
    else $error("option load missed");

  a_div_128_tap: assert property ( // RQ10
    tap && sel_e == 3'h7 |-> r.pre == 7'h7F)
    else $error("divide by 128 tap wrong");

  a_tdr_decrement: assert property ( // RQ19
    tap && !wr_tdr |=> r.tdr == $past(r.tdr) - 8'h01)
    else $error("counter not decremented");

  a_irq_out_unmask: assert property ( // RQ3
    r.irq && !r.mask |-> timer_irq)
    else $error("unmasked flag not on interrupt");

  a_mask_blocks: assert property ( // RQ4
    r.mask |-> !timer_irq)
    else $error("masked interrupt signalled");

  a_mask_hold: assert property ( // RQ4
    !wr_tcr |=> $stable(r.mask))
    else $error("mask changed without write");

  a_irq_no_spurious: assert property ( // RQ1
    !set_irq |=> !$rose(r.irq))
    else $error("request flag set without zero");

  a_irq_holds: assert property ( // RQ2
    r.irq && !wr_tcr |=> r.irq)
    else $error("request flag lost without write");

  a_legacy_fixed: assert property ( // RQ13
    s_legacy_write |=> $stable(r.src) && $stable(r.gate)
      && $stable(r.sel))
    else $error("legacy write changed clock fields");

  a_legacy_no_clear: assert property ( // RQ9
    s_legacy_write and ev |=> r.pre == $past(r.pre) + 7'h01)
    else $error("legacy write cleared prescaler");

  a_legacy_pre_hold: assert property ( // RQ9
    s_legacy_write and !ev |=> $stable(r.pre))
    else $error("legacy write moved prescaler");

  a_gate_forced: assert property ( // RQ7
    legacy |-> gate_e)
    else $error("legacy gate enable not one");

  a_internal_clk: assert property ( // RQ5
    !src_e && !gate_e |-> ev == tick)
    else $error("internal clock mode wrong");

  a_gated_clk: assert property ( // RQ6
    !src_e && gate_e |-> ev == (tick && count_pin))
    else $error("gated clock mode wrong");

  a_no_clock: assert property ( // RQ6
    src_e && !gate_e |-> !ev)
    else $error("event in no clock mode");

  a_legacy_option: assert property ( // RQ15 RQ16
    legacy |-> src_e == r.opt[TPC_B_SRC] && sel_e == r.opt[2:0])
    else $error("legacy controls not from option");

  a_opt_read: assert property ( // RQ17
    s_opt_read |=> r.rdata == {24'h000000, r.opt})
    else $error("option byte read wrong");

  a_opt_fixed: assert property ( // RQ18
    r.st == TPC_RUN |=> $stable(r.opt))
    else $error("option byte changed while running");

  a_tdr_load: assert property ( // RQ19
    s_tdr_load |=> r.tdr == $past(hwdata[7:0]))
    else $error("counter write not loaded");

  a_tdr_hold: assert property ( // RQ19
    !tap && !wr_tdr |=> $stable(r.tdr))
    else $error("counter moved without tap");

  a_bypass_tap: assert property ( // RQ10
    ev && sel_e == 3'h0 && !psc_clr |-> tap)
    else $error("bypass did not tap every event");

  a_pre_count: assert property ( // RQ10
    ev && !psc_clr |=> r.pre == $past(r.pre) + 7'h01)
    else $error("prescaler did not count event");

endmodule

// *** inc/tpc_pkg.sv ***
// Constants and types for the timer prescaler control block
package tpc_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int          TPC_DW      = 32;
  localparam logic [11:0] TPC_TDR_IDX = 12'h008;
  localparam logic [11:0] TPC_TCR_IDX = 12'h009;
  localparam logic [11:0] TPC_OPT_IDX = 12'h784;

  localparam logic [1:0]  TPC_SEL_NONE = 2'h0;
  localparam logic [1:0]  TPC_SEL_TDR  = 2'h1;
  localparam logic [1:0]  TPC_SEL_TCR  = 2'h2;
  localparam logic [1:0]  TPC_SEL_OPT  = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TPC_B_IRQ    = 7;
  localparam int TPC_B_MASK   = 6;
  localparam int TPC_B_SRC    = 5;
  localparam int TPC_B_GATE   = 4;
  localparam int TPC_B_PSC    = 3;
  localparam int TPC_B_LEGACY = 6;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] TPC_OPT_RESET = 8'h00;
  localparam logic [7:0] TPC_TDR_RESET = 8'hFF;
  localparam logic [2:0] TPC_SEL_RESET = 3'h0;
  localparam logic [6:0] TPC_PRE_RESET = 7'h00;
  localparam logic [1:0] TPC_PH2_LAST  = 2'h3;
  localparam logic [5:0] TPC_HIDDEN    = 6'h3F;

  typedef enum logic {
    TPC_LOAD,
    TPC_RUN
  } tpc_state_t;

  typedef struct packed {
    tpc_state_t  st;
    logic [7:0]  opt;
    logic        irq;
    logic        mask;
    logic        src;
    logic        gate;
    logic [2:0]  sel;
    logic [6:0]  pre;
    logic [7:0]  tdr;
    logic [1:0]  ph2;
    logic        pin_d;
    logic        wr_pend;
    logic [1:0]  wr_reg;
    logic [31:0] rdata;
  } tpc_regs_t;

endpackage

// *** dv/tpc_pin_model.sv ***
// Count pin source: event pulses or a held level
`timescale 1ns/1ps
module tpc_pin_model (
  input  wire logic mclk,
  output      logic count_pin
);
  initial count_pin = 1'b0;
  // Two cycles high, three low, so edges stay apart
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge mclk) count_pin <= 1'b1;
      repeat (2) @(posedge mclk);
      count_pin <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
  task automatic level(input logic v);
    @(posedge mclk) count_pin <= v;
  endtask
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the timer prescaler control block
`timescale 1ns/1ps
module testbench;
  import tpc_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        count_pin;
  logic        timer_irq;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [31:0] seed;
  logic [7:0]  option_pins;
  logic [7:0]  k;
  int          fail_count;
  int          n_checks;
  localparam logic [31:0] A_TDR = {18'h0, TPC_TDR_IDX, 2'h0};
  localparam logic [31:0] A_TCR = {18'h0, TPC_TCR_IDX, 2'h0};
  localparam logic [31:0] A_OPT = {18'h0, TPC_OPT_IDX, 2'h0};

  tpc_top u_tpc_top (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .count_pin(count_pin),
    .option_pins(option_pins), .timer_irq(timer_irq));
  tpc_pin_model u_pin (.mclk(mclk), .count_pin(count_pin));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rd(input string nm, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic irq(input logic e);
    @(posedge mclk);
    #1;
    chk("timer_irq", {31'h0, e}, {31'h0, timer_irq});
  endtask
  // Load counter, let it run, accept a count window
  task automatic win(input string nm, input logic [7:0] lo, hi);
    bus(1'b1, A_TDR, 32'h80);
    repeat (40) @(posedge mclk);
    bus(1'b0, A_TDR, 32'h0);
    chk(nm, 32'h1, {31'h0, q[7:0] >= lo && q[7:0] <= hi});
  endtask
  task automatic do_reset(input logic [7:0] o);
    rst_n <= 1'b0;
    option_pins <= o;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    summarize();
  end
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    rst_n = 1'b0;
    option_pins = 8'h00;
    fail_count = 0;
    n_checks = 0;
    seed = 32'hc87582c1;
    do_reset(8'h00);
    rd("tcr blank", A_TCR, 32'h40);
    rd("opt blank", A_OPT, 32'h00);
    rd("unmapped", 32'h100, 32'h0);
    $display("test reset layout done");
    for (int s = 0; s < 4; s++) begin
      seed = lfsr(seed);
      k = {6'h0, seed[1:0]} + 8'h1;
      bus(1'b1, A_TCR, 32'hE0);
      bus(1'b1, A_TDR, {24'h0, k});
      bus(1'b1, A_TCR, 32'hF8 | s);
      rd("tcr psc", A_TCR, 32'h70 | s);
      u_pin.burst(k << s);
      rd("tdr div", A_TDR, 32'h0);
      rd("tcr flag", A_TCR, 32'hF0 | s);
      irq(1'b0);
      bus(1'b1, A_TCR, 32'hB0 | s);
      irq(1'b1);
      bus(1'b1, A_TCR, 32'h20 | s);
      rd("tcr clr", A_TCR, 32'h20 | s);
      irq(1'b0);
    end
    $display("test prescale events done");
    u_pin.burst(3);
    rd("no clock", A_TDR, 32'h0);
    bus(1'b1, A_TCR, 32'hD8);
    win("gated low", 8'h80, 8'h80);
    u_pin.level(1'b1);
    win("gated high", 8'h74, 8'h77);
    u_pin.level(1'b0);
    bus(1'b1, A_TCR, 32'hC8);
    win("internal", 8'h74, 8'h77);
    $display("test clock modes done");
    do_reset(8'h35);
    rd("tcr load", A_TCR, 32'h75);
    bus(1'b1, A_OPT, 32'hFF);
    rd("opt ro", A_OPT, 32'h35);
    $display("test option load done");
    do_reset(8'h60);
    rd("tcr legacy", A_TCR, 32'h7F);
    bus(1'b1, A_TCR, 32'h08);
    rd("tcr legacy wr", A_TCR, 32'h3F);
    bus(1'b1, A_TDR, 32'h5);
    u_pin.burst(5);
    rd("legacy ext", A_TDR, 32'h0);
    irq(1'b1);
    do_reset(8'h42);
    rd("tcr reset", A_TCR, 32'h7F);
    irq(1'b0);
    win("legacy gate", 8'h80, 8'h80);
    u_pin.level(1'b1);
    win("legacy div", 8'h7D, 8'h7E);
    u_pin.level(1'b0);
    $display("test legacy layout done");
    summarize();
  end
endmodule
